// ---- hdl/irp_defines.svh ----
`ifndef IRP_DEFINES_SVH
`define IRP_DEFINES_SVH

// pointer and register address width
`define IRP_AW 9

// instruction field positions
`define IRP_OP_MSB 31
`define IRP_OP_LSB 26
`define IRP_IMM_BIT 22
`define IRP_CND_MSB 21
`define IRP_CND_LSB 18
`define IRP_DST_MSB 17
`define IRP_DST_LSB 9
`define IRP_SRC_MSB 8
`define IRP_SRC_LSB 0

// window register addresses
`define IRP_ADDR_WIN_A 9'h1F6
`define IRP_ADDR_WIN_B 9'h1F7

// opcodes of the pointer instructions
`define IRP_OP_SET 6'h38
`define IRP_OP_FIX 6'h39

// per-window condition codes of the set instruction
`define IRP_SET_LOAD 2'h1
`define IRP_SET_ADJUST 2'h3

// condition codes of the fix instruction
`define IRP_FIX_A 4'h1
`define IRP_FIX_B 4'h4
`define IRP_FIX_BOTH 4'h5

// operand modifiers
`define IRP_MOD_USE 2'h0
`define IRP_MOD_POST_INC 2'h1
`define IRP_MOD_POST_DEC 2'h2
`define IRP_MOD_PRE_INC 2'h3

// limits forced by the set instruction, and reset values
`define IRP_LIM_BOT 9'h000
`define IRP_LIM_TOP 9'h1FF
`define IRP_PTR_RESET 9'h000

// condition code that means always
`define IRP_COND_ALWAYS 4'hF

`endif

// ---- hdl/irp_pkg.sv ----
package irp_pkg;

  typedef enum logic [2:0] {
    IRP_CMD_NONE,
    IRP_CMD_LOAD,
    IRP_CMD_ADJUST,
    IRP_CMD_FIX,
    IRP_CMD_INC,
    IRP_CMD_DEC
  } irp_cmd_t;

endpackage : irp_pkg

// ---- hdl/irp_unit.sv ----
// What this block does
// - window A sits at address 1F6, window B at 1F7, in either operand field.
// - an operand naming a window reaches the register its pointer holds.
// - each window keeps a 9-bit pointer, bottom limit and top limit.
// - limits are inclusive; stepping wraps inside them to form circular buffers.
// - set instructions load or adjust pointers and force limits to 000 and 1FF.
// - fix loads initial value; bottom is smaller, top larger of initial and terminal.
// - condition upper two bits modify destination, lower two bits modify source.
// - instructions with an indirect operand always execute, ignoring condition bits.
// - modifier 00 use, 01 use then add, 10 use then subtract, 11 pre-add.
// - both operands on one window: OR the modifiers for the single update.
// - on one window only pre-increment with plain use addresses two registers.
// - set opcode 111000: B value in destination, A in source, 01 load, 11 adjust.
// - fix opcode 111001: terminal in destination, initial in source; 1, 4, 5 select.
// - adjust amounts are 9-bit signed, -256 to +255, added to the pointer.
// - absolute, terminal and initial values are 9-bit register addresses 0 to 511.
`timescale 1ns/1ps
`default_nettype none
`include "irp_defines.svh"

module irp_unit
  import irp_pkg::*;
#(
  parameter int NUM_WIN = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction from the decode stage
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  // resolved operands toward the register RAM
  output logic op_valid,
  output logic [`IRP_AW-1:0] dst_addr,
  output logic [`IRP_AW-1:0] src_addr,
  output logic dst_indirect,
  output logic src_indirect,
  output logic [3:0] cond_out,
  // pointer state
  output logic [`IRP_AW-1:0] ptr_a,
  output logic [`IRP_AW-1:0] ptr_b,
  output logic [`IRP_AW-1:0] bot_a,
  output logic [`IRP_AW-1:0] bot_b,
  output logic [`IRP_AW-1:0] top_a,
  output logic [`IRP_AW-1:0] top_b
);

  if (NUM_WIN != 2) begin : g_bad_num_win
    $error("irp_unit serves exactly two windows");
  end

  // instruction fields
  wire logic [5:0] op_field = instr[`IRP_OP_MSB:`IRP_OP_LSB];
  wire logic imm_bit = instr[`IRP_IMM_BIT];
  wire logic [3:0] cnd_field = instr[`IRP_CND_MSB:`IRP_CND_LSB];
  wire logic [`IRP_AW-1:0] d_field = instr[`IRP_DST_MSB:`IRP_DST_LSB];
  wire logic [`IRP_AW-1:0] s_field = instr[`IRP_SRC_MSB:`IRP_SRC_LSB];
  wire logic [1:0] d_mod = cnd_field[3:2];
  wire logic [1:0] s_mod = cnd_field[1:0];

  // instruction classes
  wire logic is_set = instr_valid && (op_field == `IRP_OP_SET);
  wire logic is_fix = instr_valid && (op_field == `IRP_OP_FIX);
  wire logic is_plain = instr_valid && !is_set && !is_fix;

  // window selection by operand address
  wire logic d_is_a = (d_field == `IRP_ADDR_WIN_A);
  wire logic d_is_b = (d_field == `IRP_ADDR_WIN_B);
  wire logic s_is_a = (s_field == `IRP_ADDR_WIN_A);
  wire logic s_is_b = (s_field == `IRP_ADDR_WIN_B);
  wire logic d_ind = is_plain && (d_is_a || d_is_b);
  wire logic s_ind = is_plain && !imm_bit && (s_is_a || s_is_b);
  wire logic d_win = d_is_b;
  wire logic s_win = s_is_b;

  // fix bounds: smaller and larger of initial and terminal
  wire logic fix_init_low = (s_field <= d_field);
  wire logic [`IRP_AW-1:0] fix_lo = fix_init_low ? s_field : d_field;
  wire logic [`IRP_AW-1:0] fix_hi = fix_init_low ? d_field : s_field;
  wire logic fix_a = is_fix && ((cnd_field == `IRP_FIX_A) || (cnd_field == `IRP_FIX_BOTH));
  wire logic fix_b = is_fix && ((cnd_field == `IRP_FIX_B) || (cnd_field == `IRP_FIX_BOTH));

  logic [`IRP_AW-1:0] win_ptr [NUM_WIN];
  logic [`IRP_AW-1:0] win_up [NUM_WIN];
  logic [`IRP_AW-1:0] win_bot [NUM_WIN];
  logic [`IRP_AW-1:0] win_top [NUM_WIN];
  logic [1:0] win_mod [NUM_WIN];

  irp_win_if wif [NUM_WIN] ();

  for (genvar g = 0; g < NUM_WIN; g++) begin : g_win
    wire logic d_hit = d_ind && (d_win == 1'(g));
    wire logic s_hit = s_ind && (s_win == 1'(g));
    // one update per window; shared window ORs both modifiers
    wire logic [1:0] mod_w = (d_hit && s_hit) ? (d_mod | s_mod) :
                             d_hit ? d_mod : s_hit ? s_mod : `IRP_MOD_USE;
    // set: window B takes the upper condition pair and destination field
    wire logic [1:0] set_code = (g == 1) ? cnd_field[3:2] : cnd_field[1:0];
    wire logic [`IRP_AW-1:0] set_val = (g == 1) ? d_field : s_field;
    wire logic set_load = is_set && (set_code == `IRP_SET_LOAD);
    wire logic set_adj = is_set && (set_code == `IRP_SET_ADJUST);
    wire logic fix_sel = (g == 1) ? fix_b : fix_a;

    // modifier decode into the pointer command
    assign wif[g].cmd = set_load ? IRP_CMD_LOAD :
                        set_adj ? IRP_CMD_ADJUST :
                        fix_sel ? IRP_CMD_FIX :
                        (mod_w == `IRP_MOD_POST_DEC) ? IRP_CMD_DEC :
                        (mod_w == `IRP_MOD_USE) ? IRP_CMD_NONE : IRP_CMD_INC;
    assign wif[g].val = fix_sel ? s_field : set_val;
    assign wif[g].lim_lo = fix_lo;
    assign wif[g].lim_hi = fix_hi;
    assign win_ptr[g] = wif[g].ptr;
    assign win_up[g] = wif[g].ptr_up;
    assign win_bot[g] = wif[g].bot;
    assign win_top[g] = wif[g].top;
    assign win_mod[g] = mod_w;

    irp_window u_win (
      .clk(clk),
      .nrst(nrst),
      .w(wif[g])
    );
  end

  // effective addresses; pre-increment uses the stepped value
  // on a shared window only a plain use stays apart from a pre-increment
  wire logic same_win = d_ind && s_ind && (d_win == s_win);
  wire logic d_pre = (d_mod == `IRP_MOD_PRE_INC) ||
                     (same_win && (s_mod == `IRP_MOD_PRE_INC) &&
                      (d_mod != `IRP_MOD_USE));
  wire logic s_pre = (s_mod == `IRP_MOD_PRE_INC) ||
                     (same_win && (d_mod == `IRP_MOD_PRE_INC) &&
                      (s_mod != `IRP_MOD_USE));
  wire logic [`IRP_AW-1:0] d_eff = d_pre ? win_up[d_win] : win_ptr[d_win];
  wire logic [`IRP_AW-1:0] s_eff = s_pre ? win_up[s_win] : win_ptr[s_win];
  wire logic [`IRP_AW-1:0] dst_nxt = d_ind ? d_eff : d_field;
  wire logic [`IRP_AW-1:0] src_nxt = s_ind ? s_eff : s_field;
  wire logic any_ind = d_ind || s_ind;
  wire logic [3:0] cond_nxt = any_ind ? `IRP_COND_ALWAYS : cnd_field;

  logic op_valid_r;
  logic [`IRP_AW-1:0] dst_addr_r;
  logic [`IRP_AW-1:0] src_addr_r;
  logic dst_ind_r;
  logic src_ind_r;
  logic [3:0] cond_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_valid_r <= 1'b0;
      dst_addr_r <= 9'h000;
      src_addr_r <= 9'h000;
      dst_ind_r <= 1'b0;
      src_ind_r <= 1'b0;
      cond_r <= 4'h0;
    end else begin
      op_valid_r <= is_plain;
      if (is_plain) begin
        dst_addr_r <= dst_nxt;
        src_addr_r <= src_nxt;
        dst_ind_r <= d_ind;
        src_ind_r <= s_ind;
        cond_r <= cond_nxt;
      end
    end
  end

  assign op_valid = op_valid_r;
  assign dst_addr = dst_addr_r;
  assign src_addr = src_addr_r;
  assign dst_indirect = dst_ind_r;
  assign src_indirect = src_ind_r;
  assign cond_out = cond_r;
  assign ptr_a = win_ptr[0];
  assign ptr_b = win_ptr[1];
  assign bot_a = win_bot[0];
  assign bot_b = win_bot[1];
  assign top_a = win_top[0];
  assign top_b = win_top[1];

  // helper signals watched by the checks below
  wire logic [1:0] mod_a = win_mod[0];
  wire logic [`IRP_AW-1:0] up_a = win_up[0];
  wire logic [1:0] mod_b = win_mod[1];
  wire logic [`IRP_AW-1:0] up_b = win_up[1];
  wire logic chk_set_load_a = is_set && (s_mod == `IRP_SET_LOAD);
  wire logic chk_set_adj_a = is_set && (s_mod == `IRP_SET_ADJUST);
  wire logic chk_fix_both = is_fix && (cnd_field == `IRP_FIX_BOTH);
  wire logic chk_same_a = d_ind && s_ind && !d_win && !s_win;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  AST_WIN_ADDR: assert property (
    is_plain && d_is_b |=> dst_indirect &&
      (dst_addr == ($past(d_pre) ? $past(up_b) : $past(ptr_b))))
    else $error("window B destination not resolved");

  AST_DST_PTR: assert property (
    is_plain && d_is_a && (d_mod == `IRP_MOD_USE) && !s_ind |=>
      (dst_addr == $past(ptr_a)) && (ptr_a == $past(ptr_a)))
    else $error("plain destination use did not reach the pointer");

  AST_UNCOND: assert property (
    any_ind |=> (cond_out == `IRP_COND_ALWAYS) && op_valid)
    else $error("indirect instruction not made unconditional");

  AST_SET_LOAD: assert property (
    chk_set_load_a |=> (ptr_a == $past(s_field)) && (bot_a == `IRP_LIM_BOT) &&
                       (top_a == `IRP_LIM_TOP) && !op_valid)
    else $error("set load of window A wrong");

  AST_SET_ADJ: assert property (
    chk_set_adj_a |=> ptr_a == 9'($past(ptr_a) + $past(s_field)))
    else $error("signed adjust of window A wrong");

  AST_FIX_BOTH: assert property (
    chk_fix_both |=> (ptr_b == $past(s_field)) && (ptr_a == ptr_b) &&
                     (bot_b == $past(fix_lo)) && (top_a == $past(fix_hi)))
    else $error("fix of both windows wrong");

  AST_POST_INC: assert property (
    (mod_a == `IRP_MOD_POST_INC) && (ptr_a != top_a) && !is_set && !is_fix |=>
      ptr_a == 9'($past(ptr_a) + 9'h001))
    else $error("post increment of window A wrong");

  AST_WRAP_TOP: assert property (
    (mod_a == `IRP_MOD_POST_INC) && (ptr_a == top_a) && !is_set && !is_fix |=>
      ptr_a == $past(bot_a))
    else $error("increment at top did not wrap to bottom");

  AST_SAME_WIN: assert property (
    chk_same_a && (d_mod == `IRP_MOD_PRE_INC) && (s_mod == `IRP_MOD_USE) |=>
      (dst_addr == $past(up_a)) && (src_addr == $past(win_ptr[0])) &&
      (ptr_a == $past(up_a)))
    else $error("pre increment with plain use on one window wrong");

  AST_OR_MODS: assert property (
    chk_same_a && (d_mod == `IRP_MOD_POST_INC) && (s_mod == `IRP_MOD_POST_DEC) |=>
      (ptr_a == $past(up_a)) && (dst_addr == src_addr))
    else $error("shared window modifiers not combined");

  AST_NEXT_SEES: assert property (
    chk_set_load_a ##1 (is_plain && d_is_a && (d_mod == `IRP_MOD_USE)) |=>
      dst_addr == $past(s_field, 2))
    else $error("next instruction did not see the new pointer");

  AST_ONE_REG: assert property (
    chk_same_a && (d_mod != `IRP_MOD_USE) && (s_mod != `IRP_MOD_USE) |=>
      dst_addr == src_addr)
    else $error("shared window split into two registers");

  AST_SRC_IMM: assert property (
    is_plain && imm_bit |=> !src_indirect && (src_addr == $past(s_field)))
    else $error("immediate source taken as a window");

  AST_DIRECT_DST: assert property (
    is_plain && !d_is_a && !d_is_b |=> !dst_indirect && (dst_addr == $past(d_field)))
    else $error("direct destination altered");

  AST_COND_KEEP: assert property (
    is_plain && !any_ind |=> op_valid && (cond_out == $past(cnd_field)))
    else $error("direct instruction lost its condition");

  AST_SET_LOAD_B: assert property (
    is_set && (d_mod == `IRP_SET_LOAD) |=> (ptr_b == $past(d_field)) &&
      (bot_b == `IRP_LIM_BOT) && (top_b == `IRP_LIM_TOP))
    else $error("set load of window B wrong");

  AST_SET_ADJ_B: assert property (
    is_set && (d_mod == `IRP_SET_ADJUST) |=> ptr_b == 9'($past(ptr_b) + $past(d_field)))
    else $error("signed adjust of window B wrong");

  AST_SET_KEEP_A: assert property (
    is_set && !s_mod[0] |=> (ptr_a == $past(ptr_a)) && (bot_a == $past(bot_a)) &&
      (top_a == $past(top_a)))
    else $error("set touched window A without its code");

  AST_FIX_A: assert property (
    is_fix && (cnd_field == `IRP_FIX_A) |=> (ptr_a == $past(s_field)) &&
      (bot_a == $past(fix_lo)) && (top_a == $past(fix_hi)) && (ptr_b == $past(ptr_b)))
    else $error("fix of window A wrong");

  AST_FIX_NONE: assert property (
    is_fix && !fix_a && !fix_b |=> (ptr_a == $past(ptr_a)) && (ptr_b == $past(ptr_b)) &&
      !op_valid)
    else $error("fix with an unused code changed a window");

  AST_POST_DEC_B: assert property (
    (mod_b == `IRP_MOD_POST_DEC) && (ptr_b != bot_b) |=> ptr_b == 9'($past(ptr_b) - 9'h001))
    else $error("post decrement of window B wrong");

  AST_PRE_WRAP_B: assert property (
    (mod_b == `IRP_MOD_PRE_INC) && (ptr_b == top_b) |=> ptr_b == $past(bot_b))
    else $error("pre increment at top did not wrap");

  AST_SRC_PRE_B: assert property (
    is_plain && !imm_bit && s_is_b && (s_mod == `IRP_MOD_PRE_INC) |=>
      src_indirect && (src_addr == $past(up_b)))
    else $error("pre increment source of window B wrong");

  AST_IDLE: assert property (
    !instr_valid |=> !op_valid && (ptr_a == $past(ptr_a)) && (ptr_b == $past(ptr_b)))
    else $error("idle cycle changed the state");

endmodule : irp_unit

`default_nettype wire

// ---- hdl/irp_win_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irp_defines.svh"

interface irp_win_if;
  import irp_pkg::*;
  irp_cmd_t cmd;
  logic [`IRP_AW-1:0] val;
  logic [`IRP_AW-1:0] lim_lo;
  logic [`IRP_AW-1:0] lim_hi;
  logic [`IRP_AW-1:0] ptr;
  logic [`IRP_AW-1:0] ptr_up;
  logic [`IRP_AW-1:0] bot;
  logic [`IRP_AW-1:0] top;
  modport ctl (output cmd, val, lim_lo, lim_hi, input ptr, ptr_up, bot, top);
  modport win (input cmd, val, lim_lo, lim_hi, output ptr, ptr_up, bot, top);
endinterface : irp_win_if

`default_nettype wire

// ---- hdl/irp_window.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irp_defines.svh"

module irp_window
  import irp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command from the decoder
  irp_win_if.win w
);

  logic [`IRP_AW-1:0] ptr_r;
  logic [`IRP_AW-1:0] bot_r;
  logic [`IRP_AW-1:0] top_r;
  logic [`IRP_AW-1:0] ptr_nxt;
  logic [`IRP_AW-1:0] bot_nxt;
  logic [`IRP_AW-1:0] top_nxt;
  logic [`IRP_AW-1:0] up_w;
  logic [`IRP_AW-1:0] dn_w;

  // stepping wraps inside the inclusive limits
  assign up_w = (ptr_r >= top_r) ? bot_r : ptr_r + 9'h001;
  assign dn_w = (ptr_r <= bot_r) ? top_r : ptr_r - 9'h001;

  always_comb begin
    ptr_nxt = ptr_r;
    bot_nxt = bot_r;
    top_nxt = top_r;
    case (w.cmd)
      IRP_CMD_LOAD: begin
        ptr_nxt = w.val;
        bot_nxt = `IRP_LIM_BOT;
        top_nxt = `IRP_LIM_TOP;
      end
      IRP_CMD_ADJUST: begin
        ptr_nxt = ptr_r + w.val;
        bot_nxt = `IRP_LIM_BOT;
        top_nxt = `IRP_LIM_TOP;
      end
      IRP_CMD_FIX: begin
        ptr_nxt = w.val;
        bot_nxt = w.lim_lo;
        top_nxt = w.lim_hi;
      end
      IRP_CMD_INC: ptr_nxt = up_w;
      IRP_CMD_DEC: ptr_nxt = dn_w;
      default: ptr_nxt = ptr_r;
    endcase
  end

  // three hidden values, updated in one clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr_r <= `IRP_PTR_RESET;
      bot_r <= `IRP_LIM_BOT;
      top_r <= `IRP_LIM_TOP;
    end else begin
      ptr_r <= ptr_nxt;
      bot_r <= bot_nxt;
      top_r <= top_nxt;
    end
  end

  assign w.ptr = ptr_r;
  assign w.ptr_up = up_w;
  assign w.bot = bot_r;
  assign w.top = top_r;

  AST_PTR_IN_LIMITS: assert property (@(posedge clk) disable iff (!nrst)
    (ptr_r >= bot_r) && (ptr_r <= top_r))
    else $error("pointer outside its limits");

  AST_DEC_WRAP: assert property (@(posedge clk) disable iff (!nrst)
    (w.cmd == IRP_CMD_DEC) && (ptr_r == bot_r) |=> (ptr_r == $past(top_r)))
    else $error("decrement at bottom did not wrap to top");

endmodule : irp_window

`default_nettype wire

// ---- sim/irp_ram_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module irp_ram_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // resolved operands
  input wire logic op_valid,
  input wire logic [8:0] dst_addr,
  input wire logic [8:0] src_addr,
  // source operand read back
  output logic [31:0] rd_data
);
  logic [31:0] ram_r [512];

  // each resolved instruction acts as a move from source to destination
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < 512; k++) ram_r[k] <= 32'(k);
    end else if (op_valid) begin
      ram_r[dst_addr] <= ram_r[src_addr];
    end
  end

  assign rd_data = ram_r[src_addr];
endmodule : irp_ram_model

`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irp_defines.svh"

module tb_top;
  logic clk, nrst, instr_valid, op_valid, dst_indirect, src_indirect;
  logic [31:0] instr, rd_data, r, q;
  logic [8:0] dst_addr, src_addr, ptr_a, ptr_b, bot_a, bot_b, top_a, top_b;
  logic [3:0] cond_out, e_c;
  logic [8:0] p [2], b [2], t [2], e_d, e_s;
  logic e_v, e_di, e_si;
  logic [3:0] setc [8] = '{4'h1, 4'h3, 4'h4, 4'hC, 4'h5, 4'h7, 4'hD, 4'hF};
  integer errors, n_compared, seed, j;

  irp_unit dut_u (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .op_valid(op_valid), .dst_addr(dst_addr), .src_addr(src_addr),
    .dst_indirect(dst_indirect), .src_indirect(src_indirect), .cond_out(cond_out),
    .ptr_a(ptr_a), .ptr_b(ptr_b), .bot_a(bot_a), .bot_b(bot_b), .top_a(top_a),
    .top_b(top_b));
  irp_ram_model ram_u (.clk(clk), .nrst(nrst), .op_valid(op_valid),
    .dst_addr(dst_addr), .src_addr(src_addr), .rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] mk(input logic [5:0] op, input logic i,
    input logic [3:0] c, input logic [8:0] d, input logic [8:0] s);
    return {op, 3'h0, i, c, d, s};
  endfunction : mk

  function automatic logic [8:0] inc(input int w);
    return (p[w] >= t[w]) ? b[w] : p[w] + 9'h001;
  endfunction : inc

  function automatic logic [8:0] dec(input int w);
    return (p[w] <= b[w]) ? t[w] : p[w] - 9'h001;
  endfunction : dec

  function automatic int win(input logic [8:0] a);
    return (a == `IRP_ADDR_WIN_A) ? 0 : (a == `IRP_ADDR_WIN_B) ? 1 : 2;
  endfunction : win

  task lim(input int w, input logic [8:0] v, input logic [8:0] lo, input logic [8:0] hi);
    p[w] = v;
    b[w] = lo;
    t[w] = hi;
  endtask : lim

  task upd(input int w, input logic [1:0] m);
    if (m == `IRP_MOD_POST_DEC) p[w] = dec(w);
    else if (m != `IRP_MOD_USE) p[w] = inc(w);
  endtask : upd

  task setw(input int w, input logic [1:0] m, input logic [8:0] v);
    if (m == `IRP_SET_LOAD) lim(w, v, `IRP_LIM_BOT, `IRP_LIM_TOP);
    else if (m == `IRP_SET_ADJUST) lim(w, p[w] + v, `IRP_LIM_BOT, `IRP_LIM_TOP);
  endtask : setw

  // expected effect of one taken instruction
  task model(input logic [31:0] w);
    logic [3:0] c;
    logic [8:0] d, s;
    logic sm;
    int dw, sw;
    c = w[21:18];
    d = w[17:9];
    s = w[8:0];
    dw = win(d);
    sw = w[22] ? 2 : win(s);
    if (w[31:26] == `IRP_OP_SET) begin
      setw(0, c[1:0], s);
      setw(1, c[3:2], d);
    end else if (w[31:26] == `IRP_OP_FIX) begin
      for (int k = 0; k < 2; k++)
        if (c == `IRP_FIX_BOTH || c == (k ? `IRP_FIX_B : `IRP_FIX_A))
          lim(k, s, (s < d) ? s : d, (s < d) ? d : s);
    end else begin
      e_v = 1'b1;
      e_di = dw < 2;
      e_si = sw < 2;
      sm = e_di && e_si && dw == sw;
      e_d = !e_di ? d : (c[3:2] == `IRP_MOD_PRE_INC || (sm && c[1:0] == `IRP_MOD_PRE_INC &&
        c[3:2] != `IRP_MOD_USE)) ? inc(dw) : p[dw];
      e_s = !e_si ? s : (c[1:0] == `IRP_MOD_PRE_INC || (sm && c[3:2] == `IRP_MOD_PRE_INC &&
        c[1:0] != `IRP_MOD_USE)) ? inc(sw) : p[sw];
      e_c = (e_di || e_si) ? `IRP_COND_ALWAYS : c;
      if (e_di && dw == sw) upd(dw, c[3:2] | c[1:0]);
      else begin
        if (e_di) upd(dw, c[3:2]);
        if (e_si) upd(sw, c[1:0]);
      end
    end
  endtask : model

  // drive one cycle, then check the result of the previous one
  task step(input logic v, input logic [31:0] w);
    @(posedge clk);
    instr <= w;
    instr_valid <= v;
    #1;
    chk(op_valid, e_v);
    chk(ptr_a, p[0]);
    chk(ptr_b, p[1]);
    chk(bot_a, b[0]);
    chk(bot_b, b[1]);
    chk(top_a, t[0]);
    chk(top_b, t[1]);
    if (e_v) begin
      chk(dst_addr, e_d);
      chk(src_addr, e_s);
      chk(dst_indirect, e_di);
      chk(src_indirect, e_si);
      chk(cond_out, e_c);
    end
    e_v = 1'b0;
    if (v) model(w);
  endtask : step

  task do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    instr_valid <= 1'b0;
    for (int k = 0; k < 2; k++) lim(k, `IRP_PTR_RESET, `IRP_LIM_BOT, `IRP_LIM_TOP);
    e_v = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
  endtask : do_reset

  initial begin
    #500000;
    errors++;
    print_verdict;
  end

  initial begin
    seed = 32'hF208;
    errors = 0;
    n_compared = 0;
    nrst = 1'b0;
    instr_valid = 1'b0;
    instr = 32'h0;
    do_reset;
    step(1, mk(`IRP_OP_SET, 1'b0, 4'h1, 9'h000, 9'h005));
    step(1, mk(6'h00, 1'b0, 4'h0, 9'h020, `IRP_ADDR_WIN_A));
    step(0, 32'h0);
    chk(rd_data[8:0], 9'h005);
    step(1, mk(`IRP_OP_SET, 1'b0, 4'h3, 9'h000, 9'h003));
    step(1, mk(`IRP_OP_SET, 1'b0, 4'hC, 9'h1FC, 9'h000));
    step(1, mk(`IRP_OP_SET, 1'b0, 4'h7, 9'h007, 9'h008));
    for (j = 0; j < 8; j++) step(1, mk(`IRP_OP_SET, 1'b0, setc[j], 9'h1F0, 9'h10F));
    step(1, mk(`IRP_OP_FIX, 1'b0, 4'h2, 9'h063, 9'h032));
    step(1, mk(`IRP_OP_FIX, 1'b0, 4'h4, 9'h010, 9'h01F));
    step(1, mk(`IRP_OP_FIX, 1'b0, 4'h5, 9'h063, 9'h032));
    step(1, mk(`IRP_OP_FIX, 1'b0, 4'h1, 9'h00F, 9'h008));
    $display("test pointer setup done");
    for (j = 0; j < 10; j++) step(1, mk(6'h00, 1'b0, 4'h4, `IRP_ADDR_WIN_A, 9'h005));
    for (j = 0; j < 10; j++) step(1, mk(6'h00, 1'b0, 4'h2, 9'h010, `IRP_ADDR_WIN_A));
    for (j = 0; j < 16; j++) begin
      step(1, mk(6'h28, 1'b0, j[3:0], `IRP_ADDR_WIN_A, `IRP_ADDR_WIN_A));
      step(1, mk(6'h20, 1'b0, j[3:0], `IRP_ADDR_WIN_B, `IRP_ADDR_WIN_A));
      step(1, mk(6'h20, 1'b1, j[3:0], 9'h011, `IRP_ADDR_WIN_B));
    end
    step(0, mk(`IRP_OP_SET, 1'b0, 4'h1, 9'h000, 9'h0AA));
    step(0, 32'h0);
    $display("test modifiers done");
    do_reset;
    for (j = 0; j < 400; j++) begin
      r = $random(seed);
      q = $random(seed);
      step(r[8] | r[9], mk(r[1:0] == 2'h0 ? `IRP_OP_SET : r[1:0] == 2'h1 ? `IRP_OP_FIX :
        q[31:26], q[22] & r[7], q[21:18], r[3] ? {8'hFB, r[4]} : q[17:9],
        r[5] ? {8'hFB, r[6]} : q[8:0]));
    end
    step(0, 32'h0);
    $display("test random done");
    print_verdict;
  end
endmodule : tb_top

`default_nettype wire
